// file: lcrb_pkg.sv
// shared constants, types and helpers for the lane configuration register bank
package lcrb_pkg;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] LANE_B_ADDR = 5'h12;
  localparam logic [4:0] LANE_C_ADDR = 5'h13;
  localparam logic [15:0] RD_IDLE = 16'h0000;

  // ----------------------------------------
  // field positions in a lane register
  // ----------------------------------------
  localparam int RSV_HI = 15;
  localparam int RSV_LO = 12;
  localparam int BIT_CTC = 11;
  localparam int BIT_MF_HI = 10;
  localparam int BIT_MF_LO = 9;
  localparam int BIT_LOS = 8;
  localparam int BIT_CFG1 = 7;
  localparam int BIT_CFG0 = 6;
  localparam int BIT_EMPH_HI = 5;
  localparam int BIT_EMPH_LO = 4;
  localparam int BIT_LOOP = 3;
  localparam int BIT_PRBS = 2;
  localparam int BIT_ALIGN = 1;
  localparam int BIT_PD = 0;

  // field positions in the control register (register 0)
  localparam int CTRL0_LOOP = 14;
  localparam int CTRL0_PD = 11;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [6:0] LOW_RST = 7'h02;
  localparam logic [4:0] UPPER_RST = 5'h02;
  localparam logic [3:0] STRAP_RST = 4'h0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MF_IOSTD = 2'b00,
    MF_COMMA = 2'b01,
    MF_LOS   = 2'b10,
    MF_PRBS  = 2'b11
  } lcrb_mf_e;

  typedef struct packed {
    logic cfg0;
    logic emph_bit_high;
    logic emph_bit_low;
    logic loopback;
    logic selftest;
    logic align;
    logic power_down;
  } lcrb_low_s;

  typedef struct packed {
    logic ctc;
    lcrb_mf_e mf_sel;
    logic los_det;
    logic cfg1;
  } lcrb_upper_s;

  typedef struct packed {
    logic io_hstl;
    logic comma_det;
    logic signal_lost;
    logic prbs_pass;
  } lcrb_stat_s;

  // a strap held high freezes the stored bit
  function automatic logic strap_wr(input logic strap, input logic stored, input logic wbit);
    strap_wr = strap ? stored : wbit;
  endfunction

  // a strap held high reads back as one
  function automatic logic strap_rd(input logic strap, input logic stored);
    strap_rd = strap | stored;
  endfunction

endpackage

// file: lcrb_mf_mux.sv
// multifunction pin source select for one lane
`timescale 1ns/1ps
module lcrb_mf_mux (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // select and sources
  input wire lcrb_pkg::lcrb_mf_e sel_in,
  input wire lcrb_pkg::lcrb_stat_s stat_in,
  // pin
  output logic pin_out
);
  import lcrb_pkg::*;

  logic pin_d;
  logic pin_q;

  always_comb begin
    case (sel_in)
      MF_IOSTD: pin_d = stat_in.io_hstl;
      MF_COMMA: pin_d = stat_in.comma_det;
      MF_LOS: pin_d = stat_in.signal_lost;
      MF_PRBS: pin_d = stat_in.prbs_pass;
      default: pin_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign pin_out = pin_q;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  mf_comma_a: assert property (sel_in == MF_COMMA |=> pin_out == $past(stat_in.comma_det))
    else $error("pin does not follow comma detect");
  mf_prbs_a: assert property (sel_in == MF_PRBS |=> pin_out == $past(stat_in.prbs_pass))
    else $error("pin does not follow prbs pass");

endmodule // lcrb_mf_mux

// file: lcrb_lane_low.sv
// low seven control bits of one lane register
`timescale 1ns/1ps
module lcrb_lane_low (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // write side
  input wire logic wr_in,
  input wire logic [6:0] wdata_in,
  // synchronised straps and globals
  input wire logic cfg0_strap_in,
  input wire logic selftest_strap_in,
  input wire logic align_pin_in,
  input wire logic [15:0] global_cfg_in,
  input wire logic [15:0] ctrl0_in,
  // views
  output logic [6:0] rd_bits_out,
  output lcrb_pkg::lcrb_low_s eff_out
);
  import lcrb_pkg::*;

  lcrb_low_s reg_q;
  lcrb_low_s eff_q;
  lcrb_low_s rd_v;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_q <= LOW_RST;
    end else if (wr_in) begin
      reg_q <= wdata_in;
      reg_q.cfg0 <= strap_wr(cfg0_strap_in, reg_q.cfg0, wdata_in[BIT_CFG0]);
      reg_q.selftest <= strap_wr(selftest_strap_in, reg_q.selftest, wdata_in[BIT_PRBS]);
    end
  end

  always_comb begin
    rd_v = reg_q;
    rd_v.cfg0 = strap_rd(cfg0_strap_in, reg_q.cfg0);
    rd_v.selftest = strap_rd(selftest_strap_in, reg_q.selftest);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      eff_q <= '0;
    end else begin
      eff_q.cfg0 <= rd_v.cfg0 | global_cfg_in[BIT_CFG0];
      eff_q.emph_bit_high <= reg_q.emph_bit_high | global_cfg_in[BIT_EMPH_HI];
      eff_q.emph_bit_low <= reg_q.emph_bit_low | global_cfg_in[BIT_EMPH_LO];
      eff_q.loopback <= reg_q.loopback | ctrl0_in[CTRL0_LOOP];
      eff_q.selftest <= rd_v.selftest | global_cfg_in[BIT_PRBS];
      eff_q.align <= reg_q.align & align_pin_in & global_cfg_in[BIT_ALIGN];
      eff_q.power_down <= reg_q.power_down | ctrl0_in[CTRL0_PD];
    end
  end

  assign rd_bits_out = rd_v;
  assign eff_out = eff_q;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  cfg0_protect_a: assert property (cfg0_strap_in && wr_in |=> reg_q.cfg0 == $past(reg_q.cfg0))
    else $error("cfg0 written while strap high");
  selftest_lock_a: assert property (selftest_strap_in && wr_in |=> reg_q.selftest == $past(reg_q.selftest))
    else $error("selftest written while strap high");
  emph_or_a: assert property (##1 eff_q.emph_bit_high == $past(reg_q.emph_bit_high | global_cfg_in[BIT_EMPH_HI]))
    else $error("emphasis high not ored");
  loop_or_a: assert property (ctrl0_in[CTRL0_LOOP] |=> eff_q.loopback)
    else $error("global loopback ignored");
  align_and_a: assert property (!align_pin_in |=> !eff_q.align)
    else $error("align active with pin low");
  pd_force_a: assert property (ctrl0_in[CTRL0_PD] |=> eff_q.power_down)
    else $error("global power down ignored");

endmodule // lcrb_lane_low

// file: lcrb_top.sv
// lane configuration register bank: lane c full register, lane b low bits
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module lcrb_top (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [lcrb_pkg::ADDR_W-1:0] addr_in,
  input wire logic [lcrb_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [lcrb_pkg::DATA_W-1:0] rdata_out,
  // global configuration and control registers
  input wire logic [15:0] global_cfg_in,
  input wire logic [15:0] ctrl0_in,
  // strap pins
  input wire logic cfg_strap_low_in,
  input wire logic cfg_strap_high_in,
  input wire logic selftest_strap_in,
  input wire logic align_enable_pin_in,
  // lane c status sources
  input wire lcrb_pkg::lcrb_stat_s lane_c_stat_in,
  // effective controls
  output lcrb_pkg::lcrb_upper_s lane_c_upper_out,
  output lcrb_pkg::lcrb_low_s lane_c_low_out,
  output lcrb_pkg::lcrb_low_s lane_b_low_out,
  output logic lane_c_multi_pin_out
);
  import lcrb_pkg::*;

  // ----------------------------------------
  // strap synchronisers
  // ----------------------------------------
  // order: align, selftest, cfg high, cfg low
  logic [3:0] strap_meta_q;
  logic [3:0] strap_q;
  logic cfg_low_s;
  logic cfg_high_s;
  logic selftest_s;
  logic align_s;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      strap_meta_q <= STRAP_RST;
      strap_q <= STRAP_RST;
    end else begin
      strap_meta_q <= {align_enable_pin_in, selftest_strap_in, cfg_strap_high_in, cfg_strap_low_in};
      strap_q <= strap_meta_q;
    end
  end

  assign cfg_low_s = strap_q[0];
  assign cfg_high_s = strap_q[1];
  assign selftest_s = strap_q[2];
  assign align_s = strap_q[3];

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic wr_c;
  logic wr_b;
  logic rd_c;
  logic rd_b;

  assign wr_c = wr_in && (addr_in == LANE_C_ADDR);
  assign wr_b = wr_in && (addr_in == LANE_B_ADDR);
  assign rd_c = rd_in && (addr_in == LANE_C_ADDR);
  assign rd_b = rd_in && (addr_in == LANE_B_ADDR);

  // ----------------------------------------
  // lane c upper field, bits 11:7
  // ----------------------------------------
  // bits 15:12 have no storage, so writes there vanish
  lcrb_upper_s upper_q;
  lcrb_upper_s upper_rd;
  lcrb_upper_s upper_eff_q;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      upper_q <= UPPER_RST;
    end else if (wr_c) begin
      upper_q.ctc <= wdata_in[BIT_CTC];
      upper_q.mf_sel <= lcrb_mf_e'(wdata_in[BIT_MF_HI:BIT_MF_LO]);
      upper_q.los_det <= wdata_in[BIT_LOS];
      upper_q.cfg1 <= strap_wr(cfg_high_s, upper_q.cfg1, wdata_in[BIT_CFG1]);
    end
  end

  always_comb begin
    upper_rd = upper_q;
    upper_rd.cfg1 = strap_rd(cfg_high_s, upper_q.cfg1);
  end

  // effective values, registered so outputs never glitch
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      upper_eff_q <= '0;
    end else begin
      upper_eff_q.ctc <= upper_q.ctc | global_cfg_in[BIT_CTC];
      upper_eff_q.mf_sel <= lcrb_mf_e'(upper_q.mf_sel | global_cfg_in[BIT_MF_HI:BIT_MF_LO]);
      upper_eff_q.los_det <= upper_q.los_det & global_cfg_in[BIT_LOS];
      upper_eff_q.cfg1 <= upper_rd.cfg1 | global_cfg_in[BIT_CFG1];
    end
  end

  assign lane_c_upper_out = upper_eff_q;

  // ----------------------------------------
  // low seven bits of both lanes
  // ----------------------------------------
  logic [6:0] c_low_rd;
  logic [6:0] b_low_rd;

  lcrb_lane_low u_lane_c_low (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_in(wr_c),
    .wdata_in(wdata_in[6:0]),
    .cfg0_strap_in(cfg_low_s),
    .selftest_strap_in(selftest_s),
    .align_pin_in(align_s),
    .global_cfg_in(global_cfg_in),
    .ctrl0_in(ctrl0_in),
    .rd_bits_out(c_low_rd),
    .eff_out(lane_c_low_out)
  );

  // lane b carries only the low field in this bank
  lcrb_lane_low u_lane_b_low (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_in(wr_b),
    .wdata_in(wdata_in[6:0]),
    .cfg0_strap_in(cfg_low_s),
    .selftest_strap_in(selftest_s),
    .align_pin_in(align_s),
    .global_cfg_in(global_cfg_in),
    .ctrl0_in(ctrl0_in),
    .rd_bits_out(b_low_rd),
    .eff_out(lane_b_low_out)
  );

  // ----------------------------------------
  // multifunction pin
  // ----------------------------------------
  lcrb_mf_mux u_mf_c (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .sel_in(upper_eff_q.mf_sel),
    .stat_in(lane_c_stat_in),
    .pin_out(lane_c_multi_pin_out)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [15:0] rd_view;
  logic [15:0] rdata_q;

  always_comb begin
    case (addr_in)
      LANE_C_ADDR: rd_view = {4'h0, upper_rd, c_low_rd};
      LANE_B_ADDR: rd_view = {9'h000, b_low_rd};
      default: rd_view = RD_IDLE;
    endcase
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_q <= RD_IDLE;
    end else begin
      rdata_q <= rd_in ? rd_view : RD_IDLE;
    end
  end

  assign rdata_out = rdata_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  rsv_zero_a: assert property (rd_in && addr_in == LANE_C_ADDR |=> rdata_out[RSV_HI:RSV_LO] == 4'h0)
    else $error("reserved bits read nonzero");

  ctc_eff_a: assert property (##1 lane_c_upper_out.ctc == $past(upper_q.ctc | global_cfg_in[BIT_CTC]))
    else $error("ctc not ored with global bit");

  mf_los_route_a: assert property (upper_eff_q.mf_sel == MF_LOS |=> lane_c_multi_pin_out
      == $past(lane_c_stat_in.signal_lost))
    else $error("pin does not follow signal lost");

  mf_global_or_a: assert property (global_cfg_in[BIT_MF_HI:BIT_MF_LO] == 2'b11 |=> lane_c_upper_out.mf_sel == MF_PRBS)
    else $error("global pin select ignored");

  los_and_a: assert property (!global_cfg_in[BIT_LOS] |=> !lane_c_upper_out.los_det)
    else $error("los active with global bit low");

  cfg1_lock_a: assert property (cfg_high_s && wr_c |=> upper_q.cfg1 == $past(upper_q.cfg1))
    else $error("upper config bit written while strap high");

  lane_b_upper_a: assert property (rd_in && addr_in == LANE_B_ADDR |=> rdata_out[15:7] == 9'h000)
    else $error("lane b upper bits nonzero");

  strap_reads_one_a: assert property (rd_in && addr_in == LANE_C_ADDR && cfg_high_s && selftest_s
      |=> rdata_out[BIT_CFG1] && rdata_out[BIT_PRBS])
    else $error("strapped bit does not read one");

  write_read_a: assert property (wr_c && !cfg_high_s ##1 rd_in && addr_in == LANE_C_ADDR
      |=> rdata_out[BIT_CTC:BIT_CFG1] == $past(wdata_in[BIT_CTC:BIT_CFG1], 2))
    else $error("lane c upper field readback mismatch");

  idle_read_a: assert property (!rd_in |=> rdata_out == RD_IDLE)
    else $error("read data outside read cycle");

  // ----------------------------------------
  // per-field checks
  // ----------------------------------------
  ctc_force_a: assert property (global_cfg_in[BIT_CTC] |=> lane_c_upper_out.ctc)
    else $error("global ctc bit ignored");

  ctc_write_a: assert property (wr_c |=> upper_q.ctc == $past(wdata_in[BIT_CTC]))
    else $error("ctc write lost");

  mf_iostd_a: assert property (upper_eff_q.mf_sel == MF_IOSTD |=> lane_c_multi_pin_out
      == $past(lane_c_stat_in.io_hstl))
    else $error("pin does not follow io standard");

  mf_keep_a: assert property (upper_q.mf_sel == MF_PRBS |=> lane_c_upper_out.mf_sel == MF_PRBS)
    else $error("stored pin select lost");

  los_both_a: assert property (upper_q.los_det && global_cfg_in[BIT_LOS] |=> lane_c_upper_out.los_det)
    else $error("los detect not enabled");

  los_off_a: assert property (!upper_q.los_det |=> !lane_c_upper_out.los_det)
    else $error("los active with bit clear");

  los_write_a: assert property (wr_c |=> upper_q.los_det == $past(wdata_in[BIT_LOS]))
    else $error("los enable write lost");

  cfg1_write_a: assert property (wr_c && !cfg_high_s |=> upper_q.cfg1 == $past(wdata_in[BIT_CFG1]))
    else $error("upper config write lost");

  cfg1_force_a: assert property (global_cfg_in[BIT_CFG1] |=> lane_c_upper_out.cfg1)
    else $error("global upper config bit ignored");

  cfg1_strap_a: assert property (cfg_high_s |=> lane_c_upper_out.cfg1)
    else $error("strapped upper config not effective");

  cfg0_force_a: assert property (global_cfg_in[BIT_CFG0] |=> lane_c_low_out.cfg0 && lane_b_low_out.cfg0)
    else $error("global lower config bit ignored");

  emph_low_a: assert property (global_cfg_in[BIT_EMPH_LO] |=> lane_c_low_out.emph_bit_low
      && lane_b_low_out.emph_bit_low)
    else $error("global emphasis low ignored");

  emph_high_a: assert property (global_cfg_in[BIT_EMPH_HI] |=> lane_c_low_out.emph_bit_high
      && lane_b_low_out.emph_bit_high)
    else $error("global emphasis high ignored");

  loop_stored_a: assert property (c_low_rd[BIT_LOOP] |=> lane_c_low_out.loopback)
    else $error("stored loopback ignored");

  selftest_force_a: assert property (global_cfg_in[BIT_PRBS] |=> lane_c_low_out.selftest
      && lane_b_low_out.selftest)
    else $error("global selftest bit ignored");

  align_all_a: assert property (c_low_rd[BIT_ALIGN] && align_s && global_cfg_in[BIT_ALIGN]
      |=> lane_c_low_out.align)
    else $error("align off with all enables high");

  pd_both_a: assert property (ctrl0_in[CTRL0_PD]
      |=> lane_c_low_out.power_down && lane_b_low_out.power_down)
    else $error("power down missing on a lane");

  b_strap_read_a: assert property (rd_b && selftest_s |=> rdata_out[BIT_PRBS])
    else $error("lane b strapped selftest reads zero");

  c_strap_read_a: assert property (rd_c && cfg_low_s |=> rdata_out[BIT_CFG0])
    else $error("strapped lower config reads zero");

  upper_hold_a: assert property (!wr_c |=> upper_q == $past(upper_q))
    else $error("lane c field changed without its write");

  unmapped_rd_a: assert property (rd_in && !rd_c && !rd_b |=> rdata_out == RD_IDLE)
    else $error("unmapped read returned data");

  strap_sync_a: assert property (##2 strap_q == $past({align_enable_pin_in, selftest_strap_in, cfg_strap_high_in,
      cfg_strap_low_in}, 2))
    else $error("strap sync depth wrong");

  wr_c_c: cover property (wr_c ##1 rd_in && addr_in == LANE_C_ADDR);
  los_c: cover property (lane_c_upper_out.los_det);
  rd_b_c: cover property (wr_b ##[1:4] rd_in && addr_in == LANE_B_ADDR);
  mf_prbs_c: cover property (upper_eff_q.mf_sel == MF_PRBS && lane_c_stat_in.prbs_pass);
  strap_c: cover property (cfg_high_s && wr_c);

endmodule // lcrb_top

// file: testbench.sv
// self-checking bench for the lane configuration register bank
`timescale 1ns/1ps
module testbench;
  import lcrb_pkg::*;

  // ----------------------------------------
  // design signals
  // ----------------------------------------
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] addr_in = 5'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic [15:0] global_cfg_in = 16'h0000;
  logic [15:0] ctrl0_in = 16'h0000;
  logic cfg_strap_low_in = 1'b0;
  logic cfg_strap_high_in = 1'b0;
  logic selftest_strap_in = 1'b0;
  logic align_enable_pin_in = 1'b0;
  lcrb_stat_s lane_c_stat_in = '0;
  lcrb_upper_s lane_c_upper_out;
  lcrb_low_s lane_c_low_out;
  lcrb_low_s lane_b_low_out;
  logic lane_c_multi_pin_out;

  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] lfsr_q = 32'h00014C0E;
  // reference copies of the stored bits
  logic [11:0] sc;
  logic [6:0] sb;

  always #10 sys_clk_in = ~sys_clk_in;

  lcrb_top u_lcrb_top (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .global_cfg_in(global_cfg_in),
    .ctrl0_in(ctrl0_in), .cfg_strap_low_in(cfg_strap_low_in), .cfg_strap_high_in(cfg_strap_high_in),
    .selftest_strap_in(selftest_strap_in), .align_enable_pin_in(align_enable_pin_in),
    .lane_c_stat_in(lane_c_stat_in), .lane_c_upper_out(lane_c_upper_out),
    .lane_c_low_out(lane_c_low_out), .lane_b_low_out(lane_b_low_out),
    .lane_c_multi_pin_out(lane_c_multi_pin_out)
  );

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction

  // strapped bits read as one
  function automatic logic [15:0] exp_c_rd();
    return {4'h0, sc[11:8], sc[7] | cfg_strap_high_in, sc[6] | cfg_strap_low_in, sc[5:3],
            sc[2] | selftest_strap_in, sc[1:0]};
  endfunction

  function automatic logic [15:0] exp_b_rd();
    return {9'h000, sb[6] | cfg_strap_low_in, sb[5:3], sb[2] | selftest_strap_in, sb[1:0]};
  endfunction

  function automatic logic [15:0] exp_upper();
    return {11'h000, sc[11] | global_cfg_in[11], sc[10:9] | global_cfg_in[10:9],
            sc[8] & global_cfg_in[8], sc[7] | global_cfg_in[7] | cfg_strap_high_in};
  endfunction

  function automatic logic [15:0] exp_low(input logic [6:0] s);
    return {9'h000, s[6] | global_cfg_in[6] | cfg_strap_low_in, s[5] | global_cfg_in[5],
            s[4] | global_cfg_in[4], s[3] | ctrl0_in[14], s[2] | global_cfg_in[2] | selftest_strap_in,
            s[1] & align_enable_pin_in & global_cfg_in[1], s[0] | ctrl0_in[11]};
  endfunction

  // stat packs io_hstl, comma, lost, pass from msb down
  function automatic logic [15:0] exp_pin();
    logic [1:0] mf;
    logic [3:0] st;
    mf = sc[10:9] | global_cfg_in[10:9];
    st = lane_c_stat_in;
    return {15'h0000, st[2'd3 - mf]};
  endfunction

  // ----------------------------------------
  // compares and bus cycles
  // ----------------------------------------
  task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected read data at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_eff(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected control value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    // strobe stays up for a following write; the next task drops it
    if (a == LANE_C_ADDR) begin
      sc = {d[11:8], cfg_strap_high_in ? sc[7] : d[7], cfg_strap_low_in ? sc[6] : d[6], d[5:3],
            selftest_strap_in ? sc[2] : d[2], d[1:0]};
    end
    if (a == LANE_B_ADDR) begin
      sb = {cfg_strap_low_in ? sb[6] : d[6], d[5:3], selftest_strap_in ? sb[2] : d[2], d[1:0]};
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    @(negedge sys_clk_in);
    chk_rd(rdata_out, e);
    @(posedge sys_clk_in);
  endtask

  // straps take two sync stages, the pin two more registers
  task automatic settle_chk();
    wr_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk_eff({11'h000, lane_c_upper_out}, exp_upper());
    chk_eff({9'h000, lane_c_low_out}, exp_low({sc[6:0]}));
    chk_eff({9'h000, lane_b_low_out}, exp_low(sb));
    chk_eff({15'h0000, lane_c_multi_pin_out}, exp_pin());
    @(posedge sys_clk_in);
  endtask

  task automatic wrap_up();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      $display("unexpected hang at %0t: cycle limit reached", $time);
      wrap_up();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [4:0] ua;
    sc = 12'h102;
    sb = 7'h02;
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rd_chk(LANE_C_ADDR, exp_c_rd());
    rd_chk(LANE_B_ADDR, exp_b_rd());
    settle_chk();
    // reserved bits dropped, read straight after the write
    wr(LANE_C_ADDR, 16'hFFFF);
    rd_chk(LANE_C_ADDR, exp_c_rd());
    wr(LANE_C_ADDR, 16'h0000);
    wr(LANE_B_ADDR, 16'h0000);
    wr_in <= 1'b0;
    cfg_strap_low_in <= 1'b1;
    cfg_strap_high_in <= 1'b1;
    selftest_strap_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    rd_chk(LANE_C_ADDR, exp_c_rd());
    wr(LANE_C_ADDR, 16'hFFFF);
    wr(LANE_B_ADDR, 16'h007F);
    settle_chk();
    // strapped bits written under strap must not have landed
    cfg_strap_low_in <= 1'b0;
    cfg_strap_high_in <= 1'b0;
    selftest_strap_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rd_chk(LANE_C_ADDR, exp_c_rd());
    rd_chk(LANE_B_ADDR, exp_b_rd());
    // every pin source code
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      lane_c_stat_in <= lcrb_stat_s'(r[3:0]);
      wr(LANE_C_ADDR, {5'h00, 2'(k), 9'h000});
      settle_chk();
    end
    // random traffic with random globals and straps
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      global_cfg_in <= r[15:0];
      ctrl0_in <= r[31:16];
      r = rnd();
      {cfg_strap_low_in, cfg_strap_high_in, selftest_strap_in, align_enable_pin_in} <= r[3:0];
      lane_c_stat_in <= lcrb_stat_s'(r[7:4]);
      repeat (4) @(posedge sys_clk_in);
      r = rnd();
      wr(LANE_C_ADDR, r[15:0]);
      wr(LANE_B_ADDR, r[31:16]);
      rd_chk(LANE_C_ADDR, exp_c_rd());
      rd_chk(LANE_B_ADDR, exp_b_rd());
      ua = r[20:16];
      if (ua == LANE_B_ADDR || ua == LANE_C_ADDR) begin
        ua = 5'h00;
      end
      wr(ua, r[15:0]);
      rd_chk(ua, 16'h0000);
      settle_chk();
    end
    wrap_up();
  end
endmodule // testbench
